// *** rit_regs.svh ***
`ifndef RIT_REGS_SVH
`define RIT_REGS_SVH

// ----------------------------------------
// I/O space offsets (low three address bits)
// ----------------------------------------
`define RIT_IO_CMD      3'h0
`define RIT_IO_PA       3'h1
`define RIT_IO_PB       3'h2
`define RIT_IO_PC       3'h3
`define RIT_IO_TLO      3'h4
`define RIT_IO_THI      3'h5

// ----------------------------------------
// Command byte fields
// ----------------------------------------
`define RIT_CMD_PA_DIR  0
`define RIT_CMD_PB_DIR  1
`define RIT_CMD_PC_LO   2
`define RIT_CMD_PC_HI   3
`define RIT_CMD_IEA     4
`define RIT_CMD_IEB     5
`define RIT_CMD_TM_LO   6
`define RIT_CMD_TM_HI   7
`define RIT_CMD_RESET   8'h00

// ----------------------------------------
// Port C modes
// ----------------------------------------
`define RIT_PC_ALT1     2'h0
`define RIT_PC_ALT2     2'h3
`define RIT_PC_ALT3     2'h1
`define RIT_PC_ALT4     2'h2

// ----------------------------------------
// Timer commands and modes
// ----------------------------------------
`define RIT_TM_NOP      2'h0
`define RIT_TM_STOP     2'h1
`define RIT_TM_STOP_TC  2'h2
`define RIT_TM_START    2'h3
`define RIT_TMODE_CONT  0
`define RIT_TMODE_PULSE 1

`endif

// *** rit_pkg.sv ***
package rit_pkg;
	typedef logic [7:0]  rit_byte_t;
	typedef logic [13:0] rit_cnt_t;
	typedef enum logic {
		TMR_IDLE,
		TMR_RUN
	} rit_tmr_state_t;
endpackage

// *** rit_ram.sv ***
`timescale 1ns/1ps
`default_nettype none

module rit_ram #(
	parameter int AW = 8,
	parameter int DW = 8
) (
	input  wire logic          mclk,
	input  wire logic          we,
	input  wire logic [AW-1:0] addr,
	input  wire logic [DW-1:0] wdata,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [2**AW];

	// Contents are not reset: plain static storage
	always_ff @(posedge mclk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata <= mem[addr];
	end
endmodule

`default_nettype wire

// *** rit_host_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rit_regs.svh"

module rit_host_port #(
	parameter bit CS_ACTIVE_LOW = 1'b1,
	parameter int AW            = 8
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       dev_reset,
	input  wire logic       ale,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic       io_m,
	input  wire logic       chip_sel,
	input  wire logic [7:0] muxed_addr_data_bus_in,
	output logic      [7:0] muxed_addr_data_bus_out,
	output logic            muxed_addr_data_bus_oe,
	input  wire logic [7:0] port_a_pins_in,
	output logic      [7:0] port_a_pins_out,
	output logic      [7:0] port_a_pins_oe,
	input  wire logic [7:0] port_b_pins_in,
	output logic      [7:0] port_b_pins_out,
	output logic      [7:0] port_b_pins_oe,
	input  wire logic [5:0] port_c_pins_in,
	output logic      [5:0] port_c_pins_out,
	output logic      [5:0] port_c_pins_oe,
	input  wire logic       timer_in,
	output logic            timer_out
);
	// ----------------------------------------
	// Bus strobes and address latch
	// ----------------------------------------
	logic              ale_d_r, rd_n_d_r, wr_n_d_r, tin_d_r;
	logic [AW-1:0]     addr_r;
	logic              cs_r, io_r;
	rit_pkg::rit_byte_t wr_data_r, cmd_r, io_val, ad_out_r, ram_q;
	logic              ad_oe_r, ale_fall, rd_fall, wr_rise, cs_raw;
	logic              io_wr, io_rd, ram_we;

	assign cs_raw   = CS_ACTIVE_LOW ? ~chip_sel : chip_sel;
	assign ale_fall = ale_d_r & ~ale;
	assign rd_fall  = rd_n_d_r & ~rd_n;
	assign wr_rise  = ~wr_n_d_r & wr_n;
	assign io_wr    = wr_rise & cs_r & io_r;
	assign io_rd    = rd_fall & cs_r & io_r;
	assign ram_we   = wr_rise & cs_r & ~io_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ale_d_r  <= 1'b0;
			rd_n_d_r <= 1'b1;
			wr_n_d_r <= 1'b1;
			tin_d_r  <= 1'b0;
		end else begin
			ale_d_r  <= ale;
			rd_n_d_r <= rd_n;
			wr_n_d_r <= wr_n;
			tin_d_r  <= timer_in;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			addr_r <= '0;
			cs_r   <= 1'b0;
			io_r   <= 1'b0;
		end else if (dev_reset) begin
			cs_r   <= 1'b0;
		end else if (ale_fall) begin
			addr_r <= muxed_addr_data_bus_in[AW-1:0];
			cs_r   <= cs_raw;
			io_r   <= io_m;
		end
	end

	// Write data follows the bus while strobe is low; held once it rises and stored at the rising edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_data_r <= '0;
		end else if (!wr_n) begin
			wr_data_r <= muxed_addr_data_bus_in;
		end
	end

	rit_ram #(.AW(AW), .DW(8)) u_ram (
		.mclk  (mclk),
		.we    (ram_we),
		.addr  (addr_r),
		.wdata (wr_data_r),
		.rdata (ram_q)
	);

	// ----------------------------------------
	// Command byte
	// ----------------------------------------
	logic [1:0] pc_mode, tm_cmd, hs_en;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_r <= `RIT_CMD_RESET;
		end else if (dev_reset) begin
			cmd_r <= `RIT_CMD_RESET;
		end else if (io_wr && addr_r[2:0] == `RIT_IO_CMD) begin
			cmd_r <= wr_data_r;
		end
	end

	assign pc_mode  = cmd_r[`RIT_CMD_PC_HI:`RIT_CMD_PC_LO];
	assign tm_cmd   = wr_data_r[`RIT_CMD_TM_HI:`RIT_CMD_TM_LO];
	assign hs_en[0] = (pc_mode == `RIT_PC_ALT3) || (pc_mode == `RIT_PC_ALT4);
	assign hs_en[1] = (pc_mode == `RIT_PC_ALT4);

	// ----------------------------------------
	// Ports A and B with handshake
	// ----------------------------------------
	logic [7:0] pin_in [2];
	logic [7:0] out_w  [2];
	logic [7:0] rd_w   [2];
	logic [1:0] bf_w, intr_w, dir_w, ie_w;

	assign pin_in[0] = port_a_pins_in;
	assign pin_in[1] = port_b_pins_in;
	assign dir_w     = cmd_r[`RIT_CMD_PB_DIR:`RIT_CMD_PA_DIR];
	assign ie_w      = cmd_r[`RIT_CMD_IEB:`RIT_CMD_IEA];

	for (genvar i = 0; i < 2; i++) begin : g_port
		logic [7:0] out_r, in_lat_r;
		logic       bf_r, intr_r, stb_d_r, stb, p_wr, p_rd;

		assign stb  = port_c_pins_in[3*i+2];
		assign p_wr = io_wr && addr_r[2:0] == 3'(1 + i);
		assign p_rd = io_rd && addr_r[2:0] == 3'(1 + i);

		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				out_r <= '0;
			end else if (dev_reset) begin
				out_r <= '0;
			end else if (p_wr) begin
				out_r <= wr_data_r;
			end
		end

		// Strobe flag sets are placed last and the output BF clear yields to p_wr, so a set beats a same-cycle clear
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				stb_d_r  <= 1'b1;
				in_lat_r <= '0;
				bf_r     <= 1'b0;
				intr_r   <= 1'b0;
			end else if (dev_reset) begin
				stb_d_r  <= 1'b1;
				bf_r     <= 1'b0;
				intr_r   <= 1'b0;
			end else begin
				stb_d_r <= stb;
				if (p_rd || p_wr) begin
					intr_r <= 1'b0;
					bf_r   <= p_wr & dir_w[i];
				end
				if (hs_en[i] && !dir_w[i] && stb_d_r && !stb) begin
					in_lat_r <= pin_in[i];
					bf_r     <= 1'b1;
				end
				if (hs_en[i] && !stb_d_r && stb) begin
					intr_r <= ie_w[i];
					if (dir_w[i] && !p_wr) begin
						bf_r <= 1'b0;
					end
				end
			end
		end

		assign out_w[i]  = out_r;
		assign bf_w[i]   = bf_r;
		assign intr_w[i] = intr_r;
		assign rd_w[i]   = dir_w[i] ? out_r : (hs_en[i] ? in_lat_r : pin_in[i]);
	end

	assign port_a_pins_out = out_w[0];
	assign port_b_pins_out = out_w[1];
	assign port_a_pins_oe  = {8{dir_w[0]}};
	assign port_b_pins_oe  = {8{dir_w[1]}};

	// ----------------------------------------
	// Port C: plain port or handshake control
	// ----------------------------------------
	logic [5:0] pc_out_r;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pc_out_r <= '0;
		end else if (dev_reset) begin
			pc_out_r <= '0;
		end else if (io_wr && addr_r[2:0] == `RIT_IO_PC) begin
			pc_out_r <= wr_data_r[5:0];
		end
	end

	always_comb begin
		port_c_pins_out = pc_out_r;
		case (pc_mode)
			`RIT_PC_ALT1: port_c_pins_oe = 6'h00;
			`RIT_PC_ALT2: port_c_pins_oe = 6'h3f;
			`RIT_PC_ALT3: port_c_pins_oe = 6'h3b;
			`RIT_PC_ALT4: port_c_pins_oe = 6'h1b;
			default:      port_c_pins_oe = 6'h00;
		endcase
		if (hs_en[0]) begin
			port_c_pins_out[1:0] = {bf_w[0], intr_w[0]};
		end
		if (hs_en[1]) begin
			port_c_pins_out[4:3] = {bf_w[1], intr_w[1]};
		end
	end

	// ----------------------------------------
	// 14-bit counter/timer
	// ----------------------------------------
	rit_pkg::rit_tmr_state_t tst_r;
	rit_pkg::rit_cnt_t       len_r, act_len_r, cnt_r;
	logic [1:0]              mode_r, act_mode_r;
	logic                    pend_r, stop_tc_r, tc_flag_r, tout_r, tick, tc, cmd_wr;

	assign cmd_wr = io_wr && addr_r[2:0] == `RIT_IO_CMD;
	assign tick   = timer_in & ~tin_d_r;
	assign tc     = tick && tst_r == rit_pkg::TMR_RUN && cnt_r <= 14'h0001;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			len_r  <= '0;
			mode_r <= '0;
		end else if (io_wr && addr_r[2:0] == `RIT_IO_TLO) begin
			len_r[7:0] <= wr_data_r;
		end else if (io_wr && addr_r[2:0] == `RIT_IO_THI) begin
			len_r[13:8] <= wr_data_r[5:0];
			mode_r      <= wr_data_r[7:6];
		end
	end

	// Hazard: a restart while running waits for the present terminal count
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tst_r      <= rit_pkg::TMR_IDLE;
			cnt_r      <= '0;
			act_len_r  <= '0;
			act_mode_r <= '0;
			pend_r     <= 1'b0;
			stop_tc_r  <= 1'b0;
		end else if (dev_reset) begin
			tst_r      <= rit_pkg::TMR_IDLE;
			pend_r     <= 1'b0;
			stop_tc_r  <= 1'b0;
		end else begin
			case (tst_r)
				rit_pkg::TMR_IDLE: begin
					if (cmd_wr && tm_cmd == `RIT_TM_START) begin
						cnt_r      <= len_r;
						act_len_r  <= len_r;
						act_mode_r <= mode_r;
						stop_tc_r  <= 1'b0;
						tst_r      <= rit_pkg::TMR_RUN;
					end
				end
				rit_pkg::TMR_RUN: begin
					if (cmd_wr && tm_cmd == `RIT_TM_STOP) begin
						tst_r  <= rit_pkg::TMR_IDLE;
						pend_r <= 1'b0;
					end else begin
						if (cmd_wr && tm_cmd == `RIT_TM_START) begin
							pend_r <= 1'b1;
						end
						if (cmd_wr && tm_cmd == `RIT_TM_STOP_TC) begin
							stop_tc_r <= 1'b1;
						end
						if (tc) begin
							if (pend_r) begin
								cnt_r      <= len_r;
								act_len_r  <= len_r;
								act_mode_r <= mode_r;
								pend_r     <= 1'b0;
								stop_tc_r  <= 1'b0;
							end else if (stop_tc_r || !act_mode_r[`RIT_TMODE_CONT]) begin
								tst_r <= rit_pkg::TMR_IDLE;
							end else begin
								cnt_r <= act_len_r;
							end
						end else if (tick) begin
							cnt_r <= cnt_r - 14'h0001;
						end
					end
				end
				default: tst_r <= rit_pkg::TMR_IDLE;
			endcase
		end
	end

	// Square wave high in the upper half of the count; pulse low for one cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tout_r <= 1'b1;
		end else if (act_mode_r[`RIT_TMODE_PULSE]) begin
			tout_r <= ~tc;
		end else begin
			tout_r <= tst_r != rit_pkg::TMR_RUN || cnt_r > (act_len_r >> 1);
		end
	end

	// Terminal-count flag clears on status read; a new count wins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tc_flag_r <= 1'b0;
		end else if (tc) begin
			tc_flag_r <= 1'b1;
		end else if (dev_reset || (io_rd && addr_r[2:0] == `RIT_IO_CMD)) begin
			tc_flag_r <= 1'b0;
		end
	end

	assign timer_out = tout_r;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		case (addr_r[2:0])
			`RIT_IO_CMD: io_val = {1'b0, tc_flag_r, ie_w[1], bf_w[1], intr_w[1],
			                       ie_w[0], bf_w[0], intr_w[0]};
			`RIT_IO_PA:  io_val = rd_w[0];
			`RIT_IO_PB:  io_val = rd_w[1];
			`RIT_IO_PC:  io_val = {2'b00, port_c_pins_in};
			`RIT_IO_TLO: io_val = cnt_r[7:0];
			`RIT_IO_THI: io_val = {act_mode_r, cnt_r[13:8]};
			default:     io_val = 8'h00;
		endcase
	end

	// Data valid two cycles after the latch; with no host wait that is the last update before the read freezes it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ad_out_r <= '0;
			ad_oe_r  <= 1'b0;
		end else begin
			// Frozen once the strobe falls, so a read-clear flag still reads set
			if (rd_n_d_r) begin
				ad_out_r <= io_r ? io_val : ram_q;
			end
			ad_oe_r  <= ~rd_n & cs_r & ~dev_reset;
		end
	end

	assign muxed_addr_data_bus_out = ad_out_r;
	assign muxed_addr_data_bus_oe  = ad_oe_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_reset_inputs: assert property (@(posedge mclk) disable iff (!rst_n)
		dev_reset |=> port_a_pins_oe == 8'h00 && port_b_pins_oe == 8'h00 &&
		port_c_pins_oe == 6'h00) else $error("ports not input after reset");
	a_latch_capture: assert property (@(posedge mclk) disable iff (!rst_n)
		ale_fall && !dev_reset |=> addr_r == $past(muxed_addr_data_bus_in[AW-1:0]) &&
		cs_r == $past(cs_raw) && io_r == $past(io_m)) else $error("latch missed");
	a_latch_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		!ale_fall |=> $stable(addr_r) && $stable(io_r)) else $error("latch moved");
	a_ram_route: assert property (@(posedge mclk) disable iff (!rst_n)
		ram_we |-> cs_r && !io_r && !wr_n_d_r) else $error("bad RAM write");
	a_read_drive: assert property (@(posedge mclk) disable iff (!rst_n)
		!rd_n && cs_r && !dev_reset |=> muxed_addr_data_bus_oe) else $error("no drive");
	a_no_select: assert property (@(posedge mclk) disable iff (!rst_n)
		!cs_r |=> !muxed_addr_data_bus_oe) else $error("drive unselected");
	a_ram_data: assert property (@(posedge mclk) disable iff (!rst_n)
		!io_r && $stable(addr_r) ##1 !io_r && $stable(addr_r) |=>
		muxed_addr_data_bus_out == $past(ram_q)) else $error("RAM data wrong");
	a_cmd_dir: assert property (@(posedge mclk) disable iff (!rst_n)
		cmd_wr && !dev_reset |=> port_a_pins_oe == {8{$past(wr_data_r[0])}} &&
		port_b_pins_oe == {8{$past(wr_data_r[1])}}) else $error("dir not set");
	a_tc_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		tc |=> tc_flag_r ##1 (tc_flag_r || $past(io_rd))) else $error("tc lost");
	a_alt4_pins: assert property (@(posedge mclk) disable iff (!rst_n)
		pc_mode == `RIT_PC_ALT4 |-> port_c_pins_oe == 6'h1b &&
		port_c_pins_out[1] == bf_w[0]) else $error("alt4 pins");
endmodule

`default_nettype wire

// *** rit_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Host bus master on the muxed bus
// ----------------------------------------
module rit_host_model (
	input  wire logic       mclk,
	input  wire logic [7:0] dut_q,
	input  wire logic       dut_oe,
	output logic            dev_reset,
	output logic            ale,
	output logic            rd_n,
	output logic            wr_n,
	output logic            io_m,
	output logic            chip_sel,
	output logic      [7:0] bus_d,
	output logic            bus_oe
);
	int extra;

	initial begin
		extra = 0;
		dev_reset = 1'b0;
		ale = 1'b0;
		rd_n = 1'b1;
		wr_n = 1'b1;
		io_m = 1'b0;
		chip_sel = 1'b1;
		bus_d = 8'h00;
		bus_oe = 1'b0;
	end

	task automatic step(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask

	// Address held through the falling-edge sample, then released
	task automatic addr_ph(input logic io, input logic [7:0] a, input logic cs);
		step(1);
		ale = 1'b1;
		io_m = io;
		chip_sel = ~cs;
		bus_d = a;
		bus_oe = 1'b1;
		step(1);
		ale = 1'b0;
		step(1);
		bus_oe = 1'b0;
		chip_sel = cs; // Select flips after latch: only latched level may count
		step(1 + extra);
	endtask

	task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d, input logic cs);
		addr_ph(io, a, cs);
		wr_n = 1'b0;
		bus_d = d;
		bus_oe = 1'b1;
		step(1);
		wr_n = 1'b1;
		step(1);
		bus_oe = 1'b0;
	endtask

	task automatic rd(input logic io, input logic [7:0] a, input logic cs,
			output logic [7:0] d, output logic drv);
		addr_ph(io, a, cs);
		rd_n = 1'b0;
		step(3);
		d = dut_q;
		drv = dut_oe;
		rd_n = 1'b1;
		step(1);
	endtask

	task automatic pulse_reset();
		dev_reset = 1'b1;
		step(2); // Two host clocks of reset
		dev_reset = 1'b0;
		step(1);
	endtask
endmodule

`default_nettype wire

// *** rit_host_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module rit_host_port_tb;
	logic       mclk, rst_n, dev_reset, ale, rd_n, wr_n, io_m, chip_sel;
	logic       h_oe, d_oe, t_in, t_out, t_mon;
	logic [7:0] h_d, d_q, bus_in, bus_last, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
	logic [5:0] pc_in, pc_out, pc_oe;
	logic [7:0] rq;
	logic       rv;
	int         err_total, checked, lows;

	// Released bus shows a moving pattern, never a held value
	assign bus_in = d_oe ? d_q : (h_oe ? h_d : ~bus_last);

	rit_host_port dut_u (.mclk(mclk), .rst_n(rst_n), .dev_reset(dev_reset), .ale(ale),
		.rd_n(rd_n), .wr_n(wr_n), .io_m(io_m), .chip_sel(chip_sel),
		.muxed_addr_data_bus_in(bus_in), .muxed_addr_data_bus_out(d_q),
		.muxed_addr_data_bus_oe(d_oe), .port_a_pins_in(pa_in), .port_a_pins_out(pa_out),
		.port_a_pins_oe(pa_oe), .port_b_pins_in(pb_in), .port_b_pins_out(pb_out),
		.port_b_pins_oe(pb_oe), .port_c_pins_in(pc_in), .port_c_pins_out(pc_out),
		.port_c_pins_oe(pc_oe), .timer_in(t_in), .timer_out(t_out));

	rit_host_model host_u (.mclk(mclk), .dut_q(d_q), .dut_oe(d_oe), .dev_reset(dev_reset),
		.ale(ale), .rd_n(rd_n), .wr_n(wr_n), .io_m(io_m), .chip_sel(chip_sel),
		.bus_d(h_d), .bus_oe(h_oe));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		bus_last <= bus_in;
		if (t_mon && t_out === 1'b0) begin
			lows <= lows + 1;
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checked %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// End and middle addresses plus an I/O write that must miss the array
	task automatic t_ram();
		logic [7:0] a[3] = '{8'h00, 8'h5a, 8'hff};
		foreach (a[i]) host_u.wr(1'b0, a[i], a[i] ^ 8'h3c, 1'b1);
		host_u.wr(1'b0, 8'h01, 8'h11, 1'b1);
		host_u.wr(1'b1, 8'h01, 8'hee, 1'b1);
		foreach (a[i]) begin
			host_u.rd(1'b0, a[i], 1'b1, rq, rv);
			chk(rq, a[i] ^ 8'h3c, "ram data");
			chk({7'h0, rv}, 8'h01, "ram drive");
		end
		host_u.rd(1'b0, 8'h01, 1'b1, rq, rv);
		chk(rq, 8'h11, "ram vs io");
		$display("test ram done");
	endtask

	task automatic t_ports();
		host_u.wr(1'b1, 8'h00, 8'h03, 1'b1);
		chk(pa_oe, 8'hff, "pa oe");
		chk(pb_oe, 8'hff, "pb oe");
		host_u.wr(1'b1, 8'h01, 8'ha5, 1'b1);
		host_u.wr(1'b1, 8'h02, 8'h5c, 1'b1);
		chk(pa_out, 8'ha5, "pa out");
		chk(pb_out, 8'h5c, "pb out");
		host_u.wr(1'b1, 8'h03, 8'h15, 1'b1);
		chk({2'b00, pc_out}, 8'h15, "pc data");
		host_u.wr(1'b1, 8'h00, 8'h00, 1'b1);
		chk(pa_oe, 8'h00, "pa in");
		pa_in = 8'h69;
		pc_in = 6'h2d;
		host_u.rd(1'b1, 8'h01, 1'b1, rq, rv);
		chk(rq, 8'h69, "pa read");
		host_u.rd(1'b1, 8'h03, 1'b1, rq, rv);
		chk({2'b00, rq[5:0]}, 8'h2d, "pc read");
		$display("test ports done");
	endtask

	// Every port C mode, direction mask per mode
	task automatic t_pcmodes();
		logic [1:0] m[4] = '{2'h0, 2'h3, 2'h1, 2'h2};
		logic [5:0] e[4] = '{6'h00, 6'h3f, 6'h3b, 6'h1b};
		foreach (m[i]) begin
			host_u.wr(1'b1, 8'h00, {4'h0, m[i], 2'b00}, 1'b1);
			chk({2'b00, pc_oe}, {2'b00, e[i]}, "pc mode");
		end
		// Port A strobed input with interrupt enabled
		host_u.wr(1'b1, 8'h00, 8'h14, 1'b1);
		pa_in = 8'h3c;
		pc_in = 6'h29;
		host_u.step(2);
		pa_in = 8'h00;
		pc_in = 6'h2d;
		host_u.step(2);
		chk({6'h00, pc_out[1:0]}, 8'h03, "hs flags");
		host_u.rd(1'b1, 8'h01, 1'b1, rq, rv);
		chk(rq, 8'h3c, "hs latch");
		chk({6'h00, pc_out[1:0]}, 8'h00, "hs clear");
		$display("test pc modes done");
	endtask

	// Slow host; select at latch time is the opposite of its level afterwards
	task automatic t_cs();
		host_u.extra = 3;
		host_u.wr(1'b0, 8'h10, 8'h77, 1'b1);
		host_u.wr(1'b0, 8'h10, 8'h88, 1'b0);
		host_u.rd(1'b0, 8'h10, 1'b0, rq, rv);
		chk({7'h0, rv}, 8'h00, "no drive");
		host_u.rd(1'b0, 8'h10, 1'b1, rq, rv);
		chk(rq, 8'h77, "cs write");
		host_u.extra = 0;
		$display("test cs done");
	endtask

	task automatic t_reset();
		host_u.wr(1'b1, 8'h00, 8'h0f, 1'b1);
		chk(pc_oe[0] ? 8'h01 : 8'h00, 8'h01, "pc out");
		host_u.pulse_reset();
		chk(pa_oe, 8'h00, "pa rst");
		chk(pb_oe, 8'h00, "pb rst");
		chk({2'b00, pc_oe}, 8'h00, "pc rst");
		$display("test reset done");
	endtask

	// Single-shot pulse mode, length 4: exactly one low cycle
	task automatic t_timer();
		host_u.wr(1'b1, 8'h04, 8'h04, 1'b1);
		host_u.wr(1'b1, 8'h05, 8'h80, 1'b1);
		host_u.wr(1'b1, 8'h00, 8'hc0, 1'b1);
		t_mon = 1'b1;
		repeat (6) begin
			t_in = 1'b1;
			host_u.step(2);
			t_in = 1'b0;
			host_u.step(2);
		end
		host_u.step(4);
		t_mon = 1'b0;
		chk(lows[7:0], 8'h01, "tc pulse");
		host_u.rd(1'b1, 8'h00, 1'b1, rq, rv);
		chk({7'h0, rq[6]}, 8'h01, "tc flag");
		host_u.rd(1'b1, 8'h05, 1'b1, rq, rv);
		chk(rq & 8'hc0, 8'h80, "timer mode");
		// Continuous square wave, length 4: low from count 2, high again once stopped
		host_u.wr(1'b1, 8'h05, 8'h40, 1'b1);
		host_u.wr(1'b1, 8'h00, 8'hc0, 1'b1);
		repeat (2) begin
			t_in = 1'b1;
			host_u.step(2);
			t_in = 1'b0;
			host_u.step(2);
		end
		chk({7'h0, t_out}, 8'h00, "square low");
		host_u.wr(1'b1, 8'h00, 8'h40, 1'b1);
		host_u.step(1);
		chk({7'h0, t_out}, 8'h01, "timer stop");
		$display("test timer done");
	endtask

	initial begin
		err_total = 0;
		checked = 0;
		lows = 0;
		t_mon = 1'b0;
		t_in = 1'b0;
		pa_in = 8'h00;
		pb_in = 8'h00;
		pc_in = 6'h00;
		bus_last = 8'h00;
		rst_n = 1'b0;
		repeat (12) @(posedge mclk);
		#2;
		rst_n = 1'b1;
		chk({7'h0, t_out}, 8'h01, "timer idle");
		t_ram();
		t_ports();
		t_pcmodes();
		t_cs();
		t_reset();
		t_timer();
		finish_test();
	end

	// Tests take well under a thousand cycles
	initial begin
		#400000;
		err_total++;
		finish_test();
	end
endmodule

`default_nettype wire
